// File: design/ieo_pkg.sv
// Purpose: Constants for the interrupt-enable, power-down arming and
//          port input instruction decoder.
// Assumes: 10-bit instruction words, 4-bit accumulator.
// Notes:   Opcodes are fixed by the instruction set.
package ieo_pkg;
    localparam int         IW            = 10;
    localparam int         AW            = 4;
    localparam logic [9:0] OPC_INT_ON    = 10'h005;
    localparam logic [9:0] OPC_ARM_PD    = 10'h05B;
    localparam logic [9:0] OPC_PD        = 10'h002;
    localparam logic [9:0] OPC_DEEP_PD   = 10'h008;
    localparam logic [9:0] OPC_KEY_IN    = 10'h26F;
    localparam logic [9:0] OPC_PORT0_IN  = 10'h260;
    localparam logic       INTERRUPT_ENABLE_FLAG_RST      = 1'b0;
    localparam logic [3:0] ACC_RST       = 4'h0;
    localparam int         KEY_BIT       = 0;
    // Interrupt acceptance waits this many machine cycles after enable
    localparam int         INT_DELAY_CYC = 1;

    typedef enum logic [1:0] {
        IEO_INT_OFF  = 2'b00,
        IEO_INT_WAIT = 2'b01,
        IEO_INT_ON   = 2'b10
    } ieo_int_t;
endpackage

// File: design/ieo_decoder.sv
// Purpose: Decode and execute interrupt-on, power-down arming and
//          key / port-zero input instructions.
// Assumes: One instruction per CORE_CLK machine cycle when INSTR_VALID.
// Notes:   Port pins pass a three-stage synchroniser.
// How it works
// [RULE_01] Interrupt-on opcode sets interrupt enable flag
// [RULE_02] Interrupts accepted one machine cycle later
// [RULE_03] Arming opcode validates immediately following power-down
// [RULE_04] Key input opcode copies key into bit0
// [RULE_05] Key input clears accumulator bits three to one
// [RULE_06] Port-zero opcode loads accumulator from port pins
// [RULE_07] One word, one cycle, no carry/skip
`timescale 1ns/1ns
module ieo_decoder
    import ieo_pkg::*;
(
    input  wire logic          CORE_CLK,
    input  wire logic          RST_B,
    input  wire logic          INSTR_VALID,
    input  wire logic [IW-1:0] INSTR_WORD,
    input  wire logic          INT_OFF_REQ,
    input  wire logic          KEY_PIN,
    input  wire logic [AW-1:0] INPUT_PORT_ZERO,
    output logic               INTERRUPT_ENABLE_FLAG,
    output logic               INT_ACCEPT_OK,
    output logic               PD_ENTER,
    output logic               DEEP_PD_ENTER,
    output logic               ACC_WE,
    output logic [AW-1:0]      ACC_DATA,
    output logic               CARRY_WE,
    output logic               SKIP_NEXT
);
    // Only the instruction-set word and accumulator widths are served
    if (IW != 10 || AW != 4) begin : g_bad_width
        $error("ieo_decoder: width unsupported");
    end

    //--------------------------------------------------------------
    // Decode
    //--------------------------------------------------------------
    logic int_on_hit;
    logic arm_hit;
    logic pd_hit;
    logic deep_hit;
    logic key_hit;
    logic port0_hit;

    function automatic logic op_is(input logic [IW-1:0] w,
                                   input logic [IW-1:0] op);
        op_is = (w == op);
    endfunction

    assign int_on_hit = INSTR_VALID && op_is(INSTR_WORD, OPC_INT_ON);
    assign arm_hit    = INSTR_VALID && op_is(INSTR_WORD, OPC_ARM_PD);
    assign pd_hit     = INSTR_VALID && op_is(INSTR_WORD, OPC_PD);
    assign deep_hit   = INSTR_VALID && op_is(INSTR_WORD, OPC_DEEP_PD);
    assign key_hit    = INSTR_VALID && op_is(INSTR_WORD, OPC_KEY_IN);
    assign port0_hit  = INSTR_VALID && op_is(INSTR_WORD, OPC_PORT0_IN);

    //--------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------
    logic [2:0]    key_sync_ff;
    logic          key_ff;
    logic [AW-1:0] p0_s1_ff;
    logic [AW-1:0] p0_s2_ff;
    logic [AW-1:0] p0_s3_ff;
    logic [AW-1:0] p0_ff;
    logic          nxt_key;
    logic [AW-1:0] nxt_p0;

    // A change counts once stages two and three agree
    assign nxt_key = (key_sync_ff[1] == key_sync_ff[2]) ? key_sync_ff[2]
                                                         : key_ff;
    assign nxt_p0  = (p0_s2_ff & ~(p0_s2_ff ^ p0_s3_ff))
                   | (p0_ff & (p0_s2_ff ^ p0_s3_ff));

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            key_sync_ff <= 3'h0;
            key_ff      <= 1'b0;
            p0_s1_ff    <= ACC_RST;
            p0_s2_ff    <= ACC_RST;
            p0_s3_ff    <= ACC_RST;
            p0_ff       <= ACC_RST;
        end else begin
            key_sync_ff <= {key_sync_ff[1:0], KEY_PIN};
            key_ff      <= nxt_key;
            p0_s1_ff    <= INPUT_PORT_ZERO;
            p0_s2_ff    <= p0_s1_ff;
            p0_s3_ff    <= p0_s2_ff;
            p0_ff       <= nxt_p0;
        end
    end

    //--------------------------------------------------------------
    // Interrupt enable
    //--------------------------------------------------------------
    ieo_int_t int_st_ff;
    ieo_int_t nxt_int_st;
    logic     interrupt_enable_flag_ff;
    logic     accept_ff;
    logic     nxt_interrupt_enable_flag;
    logic     nxt_accept;

    always_comb begin
        nxt_int_st = int_st_ff;
        case (int_st_ff)
            IEO_INT_OFF: begin
                if (int_on_hit) nxt_int_st = IEO_INT_WAIT; // [RULE_01]
            end
            IEO_INT_WAIT: nxt_int_st = IEO_INT_ON;          // [RULE_02]
            IEO_INT_ON:   nxt_int_st = IEO_INT_ON;
            default:      nxt_int_st = IEO_INT_OFF;
        endcase
        // Disable wins over a same-cycle enable
        if (INT_OFF_REQ) nxt_int_st = IEO_INT_OFF;
    end

    // Flag and acceptance are registered copies of the next state
    assign nxt_interrupt_enable_flag   = (nxt_int_st != IEO_INT_OFF); // [RULE_01]
    assign nxt_accept = (nxt_int_st == IEO_INT_ON);  // [RULE_02]

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            int_st_ff <= IEO_INT_OFF;
            interrupt_enable_flag_ff   <= INTERRUPT_ENABLE_FLAG_RST;
            accept_ff <= 1'b0;
        end else begin
            int_st_ff <= nxt_int_st;
            interrupt_enable_flag_ff   <= nxt_interrupt_enable_flag;
            accept_ff <= nxt_accept;
        end
    end

    assign INTERRUPT_ENABLE_FLAG = interrupt_enable_flag_ff;
    assign INT_ACCEPT_OK         = accept_ff;

    //--------------------------------------------------------------
    // Power-down arming
    //--------------------------------------------------------------
    logic armed_ff;

    // Only the instruction right after arming may use it
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B)           armed_ff <= 1'b0;
        else if (INSTR_VALID) armed_ff <= arm_hit; // [RULE_03]
    end

    assign PD_ENTER      = pd_hit && armed_ff;   // [RULE_03]
    assign DEEP_PD_ENTER = deep_hit && armed_ff; // [RULE_03]

    //--------------------------------------------------------------
    // Accumulator load
    //--------------------------------------------------------------
    logic [AW-1:0] key_word;
    logic [AW-1:0] nxt_acc;
    logic          acc_we_ff;
    logic [AW-1:0] acc_ff;

    assign key_word = {{(AW-1){1'b0}}, key_ff};        // [RULE_04] [RULE_05]
    assign nxt_acc  = key_hit ? key_word : p0_ff;      // [RULE_06]

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            acc_we_ff <= 1'b0;
            acc_ff    <= ACC_RST;
        end else begin
            acc_we_ff <= key_hit || port0_hit;
            if (key_hit || port0_hit) acc_ff <= nxt_acc;
        end
    end

    assign ACC_WE    = acc_we_ff;
    assign ACC_DATA  = acc_ff;
    assign CARRY_WE  = 1'b0; // [RULE_07]
    assign SKIP_NEXT = 1'b0; // [RULE_07]

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    int_delay_a: assert property (@(posedge CORE_CLK) // [RULE_02]
        disable iff (!RST_B)
        int_on_hit && !INT_OFF_REQ && !INTERRUPT_ENABLE_FLAG |=>
        INTERRUPT_ENABLE_FLAG && !INT_ACCEPT_OK ##1
        (INT_ACCEPT_OK || $past(INT_OFF_REQ)))
        else $error("interrupt acceptance timing wrong");
    int_set_a: assert property (@(posedge CORE_CLK) // [RULE_01]
        disable iff (!RST_B)
        int_on_hit && !INT_OFF_REQ |=> INTERRUPT_ENABLE_FLAG)
        else $error("enable flag not set");
    int_off_a: assert property (@(posedge CORE_CLK) // [RULE_01]
        disable iff (!RST_B)
        INT_OFF_REQ |=> !INTERRUPT_ENABLE_FLAG && !INT_ACCEPT_OK)
        else $error("enable flag not cleared");
    flag_hold_a: assert property (@(posedge CORE_CLK) // [RULE_01]
        disable iff (!RST_B)
        INTERRUPT_ENABLE_FLAG && !INT_OFF_REQ |=> INTERRUPT_ENABLE_FLAG)
        else $error("enable flag dropped");
    accept_flag_a: assert property (@(posedge CORE_CLK) // [RULE_02]
        disable iff (!RST_B)
        INT_ACCEPT_OK |->
        INTERRUPT_ENABLE_FLAG && $past(INTERRUPT_ENABLE_FLAG))
        else $error("interrupts accepted too early");
    pd_arm_a: assert property (@(posedge CORE_CLK) // [RULE_03]
        disable iff (!RST_B)
        (PD_ENTER || DEEP_PD_ENTER) |->
        $past(arm_hit) || $past(armed_ff && !INSTR_VALID))
        else $error("power-down without arming");
    arm_set_a: assert property (@(posedge CORE_CLK) // [RULE_03]
        disable iff (!RST_B)
        $rose(armed_ff) |-> $past(arm_hit))
        else $error("arming without arming opcode");
    pd_go_a: assert property (@(posedge CORE_CLK) // [RULE_03]
        disable iff (!RST_B)
        arm_hit ##1 pd_hit |-> PD_ENTER)
        else $error("armed power-down ignored");
    deep_go_a: assert property (@(posedge CORE_CLK) // [RULE_03]
        disable iff (!RST_B)
        arm_hit ##1 deep_hit |-> DEEP_PD_ENTER)
        else $error("armed deep power-down ignored");
    pd_refuse_a: assert property (@(posedge CORE_CLK) // [RULE_03]
        disable iff (!RST_B)
        INSTR_VALID && !arm_hit ##1 INSTR_VALID |->
        !PD_ENTER && !DEEP_PD_ENTER)
        else $error("power-down taken without arming");
    key_bit_a: assert property (@(posedge CORE_CLK) // [RULE_04]
        disable iff (!RST_B)
        key_hit |=> ACC_WE && ACC_DATA[KEY_BIT] == $past(key_ff))
        else $error("key bit not loaded");
    key_clr_a: assert property (@(posedge CORE_CLK) // [RULE_05]
        disable iff (!RST_B)
        key_hit |=> ACC_DATA[3:1] == 3'h0)
        else $error("high bits not cleared");
    port_load_a: assert property (@(posedge CORE_CLK) // [RULE_06]
        disable iff (!RST_B)
        port0_hit |=> ACC_WE && ACC_DATA == $past(p0_ff))
        else $error("port zero not loaded");
    one_cycle_a: assert property (@(posedge CORE_CLK) // [RULE_07]
        disable iff (!RST_B)
        ACC_WE |=> !ACC_WE || $past(key_hit || port0_hit))
        else $error("accumulator write lasts too long");
    acc_hold_a: assert property (@(posedge CORE_CLK) // [RULE_06]
        disable iff (!RST_B)
        !ACC_WE |-> $stable(ACC_DATA))
        else $error("accumulator changed without write");
    key_filter_a: assert property (@(posedge CORE_CLK) // [RULE_04]
        disable iff (!RST_B)
        key_sync_ff[1] == key_sync_ff[2] |=>
        key_ff == $past(key_sync_ff[2]))
        else $error("key synchroniser missed agreement");
    port_filter_a: assert property (@(posedge CORE_CLK) // [RULE_06]
        disable iff (!RST_B)
        p0_s2_ff == p0_s3_ff |=>
        p0_ff == $past(p0_s3_ff))
        else $error("port synchroniser missed agreement");
endmodule

// File: verification/ieo_tb.sv
// Purpose: Self-checking bench for the instruction decoder.
// Assumes: Pins held steady five cycles before a read opcode.
// Notes:   Accumulator results are queued and checked by a monitor.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    err_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
    import ieo_pkg::*;
    logic          clk, rst_b, valid, int_off, key;
    logic [IW-1:0] word;
    logic [AW-1:0] port0, acc, exp_v;
    logic          flag, acc_ok, pd, dpd, acc_we, carry_we, skip;
    logic [AW-1:0] exp_q[$];
    logic [31:0]   seed;
    int            err_count, compares;
    ieo_decoder ieo_decoder_inst (.CORE_CLK(clk), .RST_B(rst_b),
        .INSTR_VALID(valid), .INSTR_WORD(word), .INT_OFF_REQ(int_off),
        .KEY_PIN(key), .INPUT_PORT_ZERO(port0),
        .INTERRUPT_ENABLE_FLAG(flag), .INT_ACCEPT_OK(acc_ok),
        .PD_ENTER(pd), .DEEP_PD_ENTER(dpd), .ACC_WE(acc_we),
        .ACC_DATA(acc), .CARRY_WE(carry_we), .SKIP_NEXT(skip));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic idle(input int n);
        valid <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic issue(input logic [IW-1:0] w, input logic e_pd,
                         input logic e_dpd);
        valid <= 1'b1;
        word  <= w;
        @(negedge clk);
        `CHK("pd_enter", e_pd, pd)
        `CHK("deep_pd_enter", e_dpd, dpd)
        @(posedge clk);
    endtask
    task automatic final_report;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // Clock, monitor, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge clk) begin
        if (rst_b) begin
            `CHK("carry_we", 1'b0, carry_we)
            `CHK("skip_next", 1'b0, skip)
        end
        if (acc_we === 1'b1) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 4'hX;
            `CHK("acc_data", exp_v, acc)
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        final_report();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_b, valid, int_off, key, word, port0} = '0;
        err_count = 0;
        compares = 0;
        seed = 32'h19F5077B;
        repeat (9) @(posedge clk);
        @(negedge clk);
        `CHK("flag_rst", 1'b0, flag)
        `CHK("accept_rst", 1'b0, acc_ok)
        `CHK("acc_we_rst", 1'b0, acc_we)
        `CHK("acc_rst", ACC_RST, acc)
        @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            key <= seed[7];
            port0 <= seed[3:0];
            idle(5);
            exp_q.push_back({3'h0, seed[7]});
            exp_q.push_back(seed[3:0]);
            issue(OPC_KEY_IN, 1'b0, 1'b0);
            issue(OPC_PORT0_IN, 1'b0, 1'b0);
        end
        idle(2);
        `CHK("queue_empty", 0, exp_q.size())
        issue(OPC_INT_ON, 1'b0, 1'b0);
        valid <= 1'b0;
        @(negedge clk);
        `CHK("flag_set", 1'b1, flag)
        `CHK("accept_early", 1'b0, acc_ok)
        @(negedge clk);
        `CHK("accept_late", 1'b1, acc_ok)
        @(posedge clk);
        int_off <= 1'b1;
        issue(OPC_INT_ON, 1'b0, 1'b0);
        int_off <= 1'b0;
        idle(2);
        @(negedge clk);
        `CHK("flag_off", 1'b0, flag)
        @(posedge clk);
        issue(OPC_INT_ON, 1'b0, 1'b0);
        int_off <= 1'b1;
        valid   <= 1'b0;
        @(posedge clk);
        int_off <= 1'b0;
        @(negedge clk);
        `CHK("off_in_wait", 1'b0, acc_ok)
        `CHK("off_flag", 1'b0, flag)
        @(posedge clk);
        for (int i = 0; i < 2; i++) begin
            issue(i ? OPC_DEEP_PD : OPC_PD, 1'b0, 1'b0);
            issue(OPC_ARM_PD, 1'b0, 1'b0);
            issue(i ? OPC_DEEP_PD : OPC_PD, i == 0, i == 1);
            issue(OPC_ARM_PD, 1'b0, 1'b0);
            idle(2);
            issue(i ? OPC_DEEP_PD : OPC_PD, i == 0, i == 1);
            issue(OPC_ARM_PD, 1'b0, 1'b0);
            exp_q.push_back({3'h0, key});
            issue(OPC_KEY_IN, 1'b0, 1'b0);
            issue(i ? OPC_DEEP_PD : OPC_PD, 1'b0, 1'b0);
        end
        idle(3);
        `CHK("queue_drained", 0, exp_q.size())
        final_report();
    end
endmodule
